// ---- src/sdoc_top.sv ----
// How it works
// - On comm fault each point holds last state or goes to its fault level.
// - Fault user value drives the point off for 0, on for 1.
// - On entering program mode each point holds or applies its idle level.
// - In program mode with user value, point is off for 0, on for 1.
// - After a nonzero hold time expires, point goes to its post-timeout level.
// - Fault state lasts the hold time in seconds; zero holds forever.
// - Fault during program mode keeps program behaviour unless idle-to-fault is set.
// - Open-load detection runs on a point only while its enable bit is 1.
// - Schedule time is the shared 64-bit epoch plus the schedule's signed delta.
// - Point level comes from normal data at 0, from schedules at 1.
// - Slot indices 1 to 32 load a schedule; other values mean no schedule.
// - Schedule target 0 to 15 picks a point; other values target none.
// - Scheduled level is applied when the schedule time is reached.
// - A schedule is processed only when its sequence number changed.
// - Each slot reports inactive, active, expired, discarded or late; current is never set.
// - Late arrivals bump a rolling 16-bit counter and still drive the point.
// - Sticky per-point flags for overcurrent and for open load.
`timescale 1ns/1ns
`default_nettype none

module sdoc_top #(
    parameter int NUM_POINTS = sdoc_pkg::NUM_POINTS,
    parameter int NUM_SLOTS = sdoc_pkg::NUM_SLOTS,
    parameter int MS_CYCLES = sdoc_pkg::MS_CYCLES
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [sdoc_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [15:0] overcurrent_sense,
    input wire logic [15:0] open_load_sense,
    output logic [15:0] point_out,
    output logic [15:0] open_load_detect_on
);
    localparam int SLOT_W = $clog2(NUM_SLOTS);

    // Bus handshake and decode
    logic ack_q;
    logic [31:0] readdata_q;
    wire req = avs_read | avs_write;
    wire wr_fire = avs_write & ack_q;
    wire full_word = (avs_byteenable == 4'hf);
    wire [31:0] be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                           {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    wire in_cfg = (avs_address >= sdoc_pkg::REG_CFG_BASE) && (avs_address < sdoc_pkg::REG_EPOCH_LO);
    wire [8:0] cfg_off = avs_address - sdoc_pkg::REG_CFG_BASE;
    wire [2:0] cfg_idx = cfg_off[4:2];
    wire in_hold = (avs_address >= sdoc_pkg::REG_HOLD_BASE) && (avs_address < sdoc_pkg::REG_HOLD_END);
    wire [3:0] hold_idx = avs_address[5:2];
    wire in_slot = (avs_address >= sdoc_pkg::REG_SLOT_BASE) && (avs_address < sdoc_pkg::REG_SLOT_END);
    wire [8:0] slot_off = avs_address - sdoc_pkg::REG_SLOT_BASE;
    wire [SLOT_W-1:0] slot_rd_idx = slot_off[SLOT_W+1:2];

    // Software registers
    logic [1:0] conn_q;
    logic [15:0] out_data_q;
    logic [15:0] timed_sel_q;
    logic [15:0] cfg_q [sdoc_pkg::CFG_COUNT];
    logic [7:0] hold_time_q [NUM_POINTS];
    logic [63:0] epoch_q;
    logic [31:0] delta_q;

    // Named views of the configuration registers
    wire [15:0] comm_fault_behavior = cfg_q[sdoc_pkg::CFG_FAULT_BEH];
    wire [15:0] comm_fault_level_cfg = cfg_q[sdoc_pkg::CFG_FAULT_LVL];
    wire [15:0] idle_behavior = cfg_q[sdoc_pkg::CFG_IDLE_BEH];
    wire [15:0] idle_level_cfg = cfg_q[sdoc_pkg::CFG_IDLE_LVL];
    wire [15:0] post_timeout_level_cfg = cfg_q[sdoc_pkg::CFG_POST_LVL];
    wire [15:0] idle_to_fault_cfg = cfg_q[sdoc_pkg::CFG_IDLE_TO_FAULT];
    wire [15:0] open_load_detect_cfg = cfg_q[sdoc_pkg::CFG_OPEN_LOAD_EN];
    wire comm_fault = conn_q[sdoc_pkg::CONN_FAULT_BIT];
    wire program_mode = conn_q[sdoc_pkg::CONN_PROG_BIT];

    // Block state
    logic [6:0] us_div_q;
    logic [31:0] ms_div_q;
    logic [63:0] now_q;
    logic [15:0] sched_level_q;
    logic [15:0] level_q;
    logic [15:0] late_cnt_q;
    logic [15:0] lost_cnt_q;
    logic [7:0] last_seq_q;
    logic seq_seen_q;
    logic [15:0] oc_flag_q;
    logic [15:0] ol_flag_q;
    logic [15:0] oc_s1_q, oc_s2_q, ol_s1_q, ol_s2_q;
    sdoc_pkg::sdoc_slot_state_t slot_state_q [NUM_SLOTS];
    logic [SLOT_W-1:0] scan_q;
    logic [SLOT_W-1:0] rd_slot_q;
    logic stale_q;

    // Read-modify-write under byte enables
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [31:0] m);
        merge = (old & ~m) | (wd & m);
    endfunction

    // Waitrequest drops one cycle after the request arrives
    assign avs_waitrequest = req & ~ack_q;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req & ~ack_q;
        end
    end

    // Read data selection
    wire [31:0] rd_cfg = in_cfg ? {16'h0000, cfg_q[cfg_idx]} : 32'h0;
    wire [31:0] rd_hold = in_hold ? {24'h0, hold_time_q[hold_idx]} : 32'h0;
    wire [31:0] rd_slot = in_slot ? {29'h0, slot_state_q[slot_rd_idx]} : 32'h0;
    wire [31:0] rd_fixed =
        (avs_address == sdoc_pkg::REG_CONN) ? {30'h0, conn_q} :
        (avs_address == sdoc_pkg::REG_OUT_DATA) ? {16'h0000, out_data_q} :
        (avs_address == sdoc_pkg::REG_TIMED_SEL) ? {16'h0000, timed_sel_q} :
        (avs_address == sdoc_pkg::REG_EPOCH_LO) ? epoch_q[31:0] :
        (avs_address == sdoc_pkg::REG_EPOCH_HI) ? epoch_q[63:32] :
        (avs_address == sdoc_pkg::REG_SCHED_DELTA) ? delta_q :
        (avs_address == sdoc_pkg::REG_TIME_LO) ? now_q[31:0] :
        (avs_address == sdoc_pkg::REG_TIME_HI) ? now_q[63:32] :
        (avs_address == sdoc_pkg::REG_COUNTS) ? {lost_cnt_q, late_cnt_q} :
        (avs_address == sdoc_pkg::REG_POINT_STATUS) ? {sched_level_q, level_q} :
        (avs_address == sdoc_pkg::REG_FLAGS) ? {ol_flag_q, oc_flag_q} : 32'h0;
    wire [31:0] rd_mux = rd_fixed | rd_cfg | rd_hold | rd_slot;
    // Addressed register merged with the written byte lanes
    wire [31:0] wr_word = merge(rd_mux, avs_writedata, be_mask);

    // Read data captured on the request edge, held for the sampling edge
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            readdata_q <= sdoc_pkg::RST_WORD;
        end else if (avs_read & ~ack_q) begin
            readdata_q <= rd_mux;
        end
    end
    assign avs_readdata = readdata_q;

    // Plain register writes
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            conn_q <= 2'b00;
            out_data_q <= sdoc_pkg::RST_POINTS;
            timed_sel_q <= sdoc_pkg::RST_POINTS;
            epoch_q <= 64'h0;
            delta_q <= sdoc_pkg::RST_WORD;
        end else if (wr_fire) begin
            if (avs_address == sdoc_pkg::REG_CONN) conn_q <= wr_word[1:0];
            if (avs_address == sdoc_pkg::REG_OUT_DATA) out_data_q <= wr_word[15:0];
            if (avs_address == sdoc_pkg::REG_TIMED_SEL) timed_sel_q <= wr_word[15:0];
            if (avs_address == sdoc_pkg::REG_EPOCH_LO) epoch_q[31:0] <= wr_word;
            if (avs_address == sdoc_pkg::REG_EPOCH_HI) epoch_q[63:32] <= wr_word;
            if (avs_address == sdoc_pkg::REG_SCHED_DELTA) delta_q <= wr_word;
        end
    end

    // Per-point configuration and hold time registers
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < sdoc_pkg::CFG_COUNT; i++) cfg_q[i] <= sdoc_pkg::RST_POINTS;
            for (int i = 0; i < NUM_POINTS; i++) hold_time_q[i] <= sdoc_pkg::RST_HOLD;
        end else if (wr_fire) begin
            if (in_cfg) cfg_q[cfg_idx] <= wr_word[15:0];
            if (in_hold && avs_byteenable[0]) hold_time_q[hold_idx] <= avs_writedata[7:0];
        end
    end

    // Schedule submission decode
    wire sub_fire = wr_fire && full_word && (avs_address == sdoc_pkg::REG_SCHED_SUBMIT);
    wire [7:0] sub_idx = avs_writedata[sdoc_pkg::SUB_IDX_LSB +: 8];
    wire [7:0] sub_seq = avs_writedata[sdoc_pkg::SUB_SEQ_LSB +: 8];
    wire [7:0] sub_tgt = avs_writedata[sdoc_pkg::SUB_TGT_LSB +: 8];
    wire sub_lvl = avs_writedata[sdoc_pkg::SUB_LVL_BIT];
    wire sub_new = sub_fire && (!seq_seen_q || (sub_seq != last_seq_q));
    wire sub_skip = seq_seen_q && (sub_seq != last_seq_q + 8'h01);
    wire sub_slot_ok = (sub_idx >= sdoc_pkg::SLOT_FIRST) && (sub_idx <= sdoc_pkg::SLOT_LAST);
    wire sub_tgt_ok = (sub_tgt <= sdoc_pkg::TARGET_LAST);
    wire [7:0] sub_slot8 = sub_idx - sdoc_pkg::SLOT_FIRST;
    wire [SLOT_W-1:0] sub_slot = sub_slot8[SLOT_W-1:0];
    wire [63:0] sub_time = epoch_q + {{32{delta_q[31]}}, delta_q};
    wire sub_late = (sub_time < now_q);
    wire sub_store = sub_new && sub_slot_ok && sub_tgt_ok;

    // Slot store, written on accepted submissions, read by the scanner
    sdoc_mem_if #(.DEPTH(NUM_SLOTS), .WIDTH(sdoc_pkg::ENTRY_W)) mem_bus ();
    sdoc_slot_mem #(.DEPTH(NUM_SLOTS), .WIDTH(sdoc_pkg::ENTRY_W)) u_slot_mem (
        .clk(clk),
        .reset_n(reset_n),
        .port(mem_bus.mem)
    );
    assign mem_bus.we = sub_store;
    assign mem_bus.waddr = sub_slot;
    assign mem_bus.wdata = {sub_lvl, sub_tgt[3:0], sub_time};
    assign mem_bus.raddr = scan_q;

    // Scanner view of the slot just read
    wire [63:0] ent_time = mem_bus.rdata[63:0];
    wire [3:0] ent_tgt = mem_bus.rdata[67:64];
    wire ent_lvl = mem_bus.rdata[68];
    wire ent_pending = (slot_state_q[rd_slot_q] == sdoc_pkg::SDOC_ACTIVE) ||
                       (slot_state_q[rd_slot_q] == sdoc_pkg::SDOC_LATE);
    wire ent_due = ent_pending && !stale_q && (now_q >= ent_time) &&
                   !(sub_new && sub_slot_ok && (sub_slot == rd_slot_q));

    // Sequence tracking and the two rolling counters
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            last_seq_q <= 8'h00;
            seq_seen_q <= 1'b0;
            late_cnt_q <= 16'h0000;
            lost_cnt_q <= 16'h0000;
        end else if (sub_new) begin
            last_seq_q <= sub_seq;
            seq_seen_q <= 1'b1;
            if (sub_skip) lost_cnt_q <= lost_cnt_q + 16'h0001;
            if (sub_store && sub_late) late_cnt_q <= late_cnt_q + 16'h0001;
        end
    end

    // Slot states: submission wins over the scanner for the same slot
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < NUM_SLOTS; i++) slot_state_q[i] <= sdoc_pkg::SDOC_INACTIVE;
        end else begin
            if (ent_due) slot_state_q[rd_slot_q] <= sdoc_pkg::SDOC_EXPIRED;
            if (sub_new && sub_slot_ok) begin
                if (!sub_tgt_ok) slot_state_q[sub_slot] <= sdoc_pkg::SDOC_DISCARDED;
                else if (sub_late) slot_state_q[sub_slot] <= sdoc_pkg::SDOC_LATE;
                else slot_state_q[sub_slot] <= sdoc_pkg::SDOC_ACTIVE;
            end
        end
    end

    // Round-robin scan; a read racing a write to the same slot is discarded
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            scan_q <= '0;
            rd_slot_q <= '0;
            stale_q <= 1'b0;
        end else begin
            scan_q <= scan_q + 1'b1;
            rd_slot_q <= scan_q;
            stale_q <= sub_store && (sub_slot == scan_q);
        end
    end

    // Scheduled level per point, late entries still apply
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sched_level_q <= sdoc_pkg::RST_POINTS;
        end else if (ent_due) begin
            sched_level_q[ent_tgt] <= ent_lvl;
        end
    end

    // Microsecond time base and millisecond tick
    wire us_tick = (us_div_q == 7'(sdoc_pkg::US_CYCLES - 1));
    wire ms_tick = (ms_div_q == 32'(MS_CYCLES - 1));
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            us_div_q <= 7'h00;
            ms_div_q <= 32'h0;
            now_q <= 64'h0;
        end else begin
            us_div_q <= us_tick ? 7'h00 : us_div_q + 7'h01;
            ms_div_q <= ms_tick ? 32'h0 : ms_div_q + 32'h1;
            if (us_tick) now_q <= now_q + 64'h1;
        end
    end

    // Pin inputs pass two flip-flops
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            oc_s1_q <= 16'h0000;
            oc_s2_q <= 16'h0000;
            ol_s1_q <= 16'h0000;
            ol_s2_q <= 16'h0000;
        end else begin
            oc_s1_q <= overcurrent_sense;
            oc_s2_q <= oc_s1_q;
            ol_s1_q <= open_load_sense;
            ol_s2_q <= ol_s1_q;
        end
    end

    // Sticky fault flags, write one to clear, a new event wins over the clear
    wire flags_wr = wr_fire && (avs_address == sdoc_pkg::REG_FLAGS);
    wire [31:0] flags_clr = flags_wr ? (avs_writedata & be_mask) : 32'h0;
    wire [15:0] ol_set = ol_s2_q & open_load_detect_cfg;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            oc_flag_q <= 16'h0000;
            ol_flag_q <= 16'h0000;
        end else begin
            oc_flag_q <= oc_s2_q | (oc_flag_q & ~flags_clr[sdoc_pkg::FLAG_OC_LSB +: 16]);
            ol_flag_q <= ol_set | (ol_flag_q & ~flags_clr[sdoc_pkg::FLAG_OL_LSB +: 16]);
        end
    end

    // Per-point mode selection and fault hold timer
    generate
        for (genvar p = 0; p < NUM_POINTS; p++) begin : g_point
            logic [sdoc_pkg::HOLD_CNT_W-1:0] hold_ms_q;
            logic hold_done_q;
            wire [sdoc_pkg::HOLD_CNT_W-1:0] hold_limit =
                sdoc_pkg::HOLD_CNT_W'(hold_time_q[p] * sdoc_pkg::MS_PER_S);
            wire hold_nz = (hold_time_q[p] != 8'h00);
            wire fault_act = comm_fault && (!program_mode || idle_to_fault_cfg[p]);
            wire idle_act = program_mode && !fault_act;
            wire normal_lvl = timed_sel_q[p] ? sched_level_q[p] : out_data_q[p];
            wire fault_lvl = comm_fault_behavior[p] ? comm_fault_level_cfg[p] : level_q[p];
            wire idle_lvl = idle_behavior[p] ? idle_level_cfg[p] : level_q[p];
            wire level_d = fault_act ? ((hold_nz && hold_done_q) ? post_timeout_level_cfg[p] : fault_lvl) :
                           idle_act ? idle_lvl : normal_lvl;

            // Timer runs from fault entry; zero hold time never expires
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    hold_ms_q <= '0;
                    hold_done_q <= 1'b0;
                end else if (!fault_act) begin
                    hold_ms_q <= '0;
                    hold_done_q <= 1'b0;
                end else if (ms_tick && hold_nz && !hold_done_q) begin
                    hold_ms_q <= hold_ms_q + 1'b1;
                    hold_done_q <= (hold_ms_q + 1'b1 >= hold_limit);
                end
            end

            // Driven output level
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    level_q[p] <= 1'b0;
                end else begin
                    level_q[p] <= level_d;
                end
            end
        end
    endgenerate

    assign point_out = level_q;
    assign open_load_detect_on = open_load_detect_cfg;
endmodule

`default_nettype wire

// ---- src/sdoc_pkg.sv ----
package sdoc_pkg;

    // Sizes
    localparam int NUM_POINTS = 16;
    localparam int NUM_SLOTS = 32;
    localparam int ADDR_W = 9;
    localparam int TIME_W = 64;
    localparam int ENTRY_W = 69;
    localparam int HOLD_CNT_W = 18;

    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int US_NS = 1000;
    localparam int US_CYCLES = US_NS / CLK_PERIOD_NS;
    localparam int MS_NS = 1000000;
    localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
    localparam int MS_PER_S = 1000;

    // Register byte offsets
    localparam logic [8:0] REG_CONN = 9'h000;
    localparam logic [8:0] REG_OUT_DATA = 9'h004;
    localparam logic [8:0] REG_TIMED_SEL = 9'h008;
    localparam logic [8:0] REG_CFG_BASE = 9'h00c;
    localparam logic [8:0] REG_EPOCH_LO = 9'h028;
    localparam logic [8:0] REG_EPOCH_HI = 9'h02c;
    localparam logic [8:0] REG_SCHED_DELTA = 9'h030;
    localparam logic [8:0] REG_SCHED_SUBMIT = 9'h034;
    localparam logic [8:0] REG_TIME_LO = 9'h038;
    localparam logic [8:0] REG_TIME_HI = 9'h03c;
    localparam logic [8:0] REG_COUNTS = 9'h040;
    localparam logic [8:0] REG_POINT_STATUS = 9'h044;
    localparam logic [8:0] REG_FLAGS = 9'h048;
    localparam logic [8:0] REG_HOLD_BASE = 9'h080;
    localparam logic [8:0] REG_HOLD_END = 9'h0c0;
    localparam logic [8:0] REG_SLOT_BASE = 9'h0c0;
    localparam logic [8:0] REG_SLOT_END = 9'h140;

    // Per-point configuration registers, in address order from REG_CFG_BASE
    localparam int CFG_FAULT_BEH = 0;
    localparam int CFG_FAULT_LVL = 1;
    localparam int CFG_IDLE_BEH = 2;
    localparam int CFG_IDLE_LVL = 3;
    localparam int CFG_POST_LVL = 4;
    localparam int CFG_IDLE_TO_FAULT = 5;
    localparam int CFG_OPEN_LOAD_EN = 6;
    localparam int CFG_COUNT = 7;

    // Field positions
    localparam int CONN_FAULT_BIT = 0;
    localparam int CONN_PROG_BIT = 1;
    localparam int SUB_IDX_LSB = 0;
    localparam int SUB_SEQ_LSB = 8;
    localparam int SUB_TGT_LSB = 16;
    localparam int SUB_LVL_BIT = 24;
    localparam int CNT_LATE_LSB = 0;
    localparam int CNT_LOST_LSB = 16;
    localparam int FLAG_OC_LSB = 0;
    localparam int FLAG_OL_LSB = 16;

    // Slot index and target encodings
    localparam logic [7:0] SLOT_FIRST = 8'h01;
    localparam logic [7:0] SLOT_LAST = 8'h20;
    localparam logic [7:0] TARGET_LAST = 8'h0f;

    // Reset values
    localparam logic [15:0] RST_POINTS = 16'h0000;
    localparam logic [7:0] RST_HOLD = 8'h00;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;

    typedef enum logic [2:0] {
        SDOC_INACTIVE = 3'b000,
        SDOC_ACTIVE = 3'b001,
        SDOC_CURRENT = 3'b010,
        SDOC_EXPIRED = 3'b011,
        SDOC_DISCARDED = 3'b100,
        SDOC_LATE = 3'b101
    } sdoc_slot_state_t;

endpackage

// ---- src/sdoc_mem_if.sv ----
`timescale 1ns/1ns
`default_nettype none

// Write and read ports of the schedule slot store
interface sdoc_mem_if #(
    parameter int DEPTH = sdoc_pkg::NUM_SLOTS,
    parameter int WIDTH = sdoc_pkg::ENTRY_W
);
    logic we;
    logic [$clog2(DEPTH)-1:0] waddr;
    logic [WIDTH-1:0] wdata;
    logic [$clog2(DEPTH)-1:0] raddr;
    logic [WIDTH-1:0] rdata;

    modport owner (output we, output waddr, output wdata, output raddr, input rdata);
    modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

`default_nettype wire

// ---- src/sdoc_slot_mem.sv ----
`timescale 1ns/1ns
`default_nettype none

// Schedule slot store, one write and one registered read per cycle
module sdoc_slot_mem #(
    parameter int DEPTH = sdoc_pkg::NUM_SLOTS,
    parameter int WIDTH = sdoc_pkg::ENTRY_W
) (
    input wire logic clk,
    input wire logic reset_n,
    sdoc_mem_if.mem port
);
    logic [WIDTH-1:0] store [DEPTH];
    logic [WIDTH-1:0] rdata_q;

    // Array write, no reset on the storage
    always_ff @(posedge clk) begin
        if (port.we) begin
            store[port.waddr] <= port.wdata;
        end
    end

    // Read data register; a read of the slot being written returns the old word
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= store[port.raddr];
        end
    end

    assign port.rdata = rdata_q;
endmodule

`default_nettype wire

// ---- testbench/sdoc_top_chk.sv ----
`timescale 1ns/1ns
`default_nettype none

module sdoc_top_chk (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [sdoc_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic [15:0] point_out,
    input wire logic [15:0] open_load_detect_on
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    logic req;
    logic done;
    logic ol_wr;
    // Request, completion and open-load enable write decodes
    assign req = avs_read | avs_write;
    assign done = req & !avs_waitrequest;
    assign ol_wr = done & avs_write & (avs_address == sdoc_pkg::REG_CFG_BASE + 9'h018) & (avs_byteenable == 4'hf);
    sequence s_wait_then_done;
        avs_waitrequest ##1 !avs_waitrequest;
    endsequence
    property p_one_wait;
        req && !$past(req) |-> s_wait_then_done;
    endproperty
    property p_idle_ready;
        !req |-> !avs_waitrequest;
    endproperty
    property p_ol_follow;
        ol_wr |=> open_load_detect_on == $past(avs_writedata[15:0]);
    endproperty
    property p_ol_hold;
        !ol_wr |=> $stable(open_load_detect_on);
    endproperty
    property p_unmapped;
        done && avs_read && avs_address >= sdoc_pkg::REG_SLOT_END |-> avs_readdata == 32'h0;
    endproperty
    property p_slot_state;
        done && avs_read && avs_address >= sdoc_pkg::REG_SLOT_BASE && avs_address < sdoc_pkg::REG_SLOT_END
            |-> avs_readdata[31:3] == 29'h0 && avs_readdata[2:0] <= 3'h5 && avs_readdata[2:0] != 3'h2;
    endproperty
    property p_status;
        done && avs_read && avs_address == sdoc_pkg::REG_POINT_STATUS |-> avs_readdata[15:0] == $past(point_out);
    endproperty
    property p_rd_stand;
        !avs_read |=> $stable(avs_readdata);
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("wait length");
    a_idle_ready: assert property (p_idle_ready) else $error("idle wait");
    a_ol_follow: assert property (p_ol_follow) else $error("ol write");
    a_ol_hold: assert property (p_ol_hold) else $error("ol moved");
    a_unmapped: assert property (p_unmapped) else $error("unmapped");
    a_slot_state: assert property (p_slot_state) else $error("slot state");
    a_status: assert property (p_status) else $error("status");
    a_rd_stand: assert property (p_rd_stand) else $error("read data");
endmodule

bind sdoc_top sdoc_top_chk chk_u (.clk(clk), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .point_out(point_out),
    .open_load_detect_on(open_load_detect_on));

`default_nettype wire

// ---- testbench/sdoc_ctrl_model.sv ----
`timescale 1ns/1ns
`default_nettype none

module sdoc_ctrl_model (
    input wire logic clk,
    input wire logic avs_waitrequest,
    input wire logic [31:0] avs_readdata,
    output logic [sdoc_pkg::ADDR_W-1:0] avs_address,
    output logic avs_read,
    output logic avs_write,
    output logic [31:0] avs_writedata,
    output logic [31:0] rdata_q,
    output logic [7:0] rcount_q
);
    // Idle bus at time zero
    initial {avs_address, avs_read, avs_write, avs_writedata, rdata_q, rcount_q} = '0;
    // One transfer held until waitrequest is seen low; ok stays low on a hang
    task automatic xfer(input logic w, input logic [8:0] a, input logic [31:0] d, output logic ok);
        int n;
        ok = 1'b0;
        @(posedge clk);
        avs_read <= !w;
        avs_write <= w;
        avs_address <= a;
        avs_writedata <= d;
        for (n = 0; n < 64 && !ok; n++) begin
            @(posedge clk);
            ok = !avs_waitrequest;
        end
        if (ok && !w) begin
            rdata_q <= avs_readdata;
            rcount_q <= rcount_q + 8'h01;
        end
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        avs_address <= ~a;
        avs_writedata <= ~d;
    endtask
endmodule

`default_nettype wire

// ---- testbench/testbench.sv ----
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin n_tests++; if ((e) !== (g)) begin err_count++; $display("wrong value %s expected %h seen %h", n, e, g); end end

module testbench;
    localparam logic [8:0] C = sdoc_pkg::REG_CFG_BASE;
    localparam logic [8:0] ST = sdoc_pkg::REG_POINT_STATUS;
    localparam logic [8:0] SUB = sdoc_pkg::REG_SCHED_SUBMIT;
    localparam logic [8:0] CN = sdoc_pkg::REG_CONN;
    localparam logic [8:0] SL = sdoc_pkg::REG_SLOT_BASE;
    logic clk, reset_n, rd_e, wr_e, wt;
    logic [8:0] adr;
    logic [31:0] wd, rdat, rq, eq;
    logic [15:0] oc, ol, pout, olon, od, fb, fl, pl, ib, il, oe, ex;
    logic [7:0] rc;
    logic [7:0] seen = 8'h00;
    logic [31:0] exp_q[$];
    int err_count = 0, n_tests = 0, cyc = 0, seed = 32'hfb6c;
    sdoc_top #(.MS_CYCLES(10)) dut_u (.clk(clk), .reset_n(reset_n), .avs_address(adr), .avs_read(rd_e),
        .avs_write(wr_e), .avs_writedata(wd), .avs_byteenable(4'hf), .avs_readdata(rdat), .avs_waitrequest(wt),
        .overcurrent_sense(oc), .open_load_sense(ol), .point_out(pout), .open_load_detect_on(olon));
    sdoc_ctrl_model ctrl_u (.clk(clk), .avs_waitrequest(wt), .avs_readdata(rdat), .avs_address(adr),
        .avs_read(rd_e), .avs_write(wr_e), .avs_writedata(wd), .rdata_q(rq), .rcount_q(rc));
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic go(input logic w, input logic [8:0] a, input logic [31:0] d);
        logic ok;
        ctrl_u.xfer(w, a, d, ok);
        if (!ok) begin
            err_count++;
            conclude();
        end
    endtask
    task automatic wr(input logic [8:0] a, input logic [31:0] d);
        go(1'b1, a, d);
    endtask
    task automatic rd(input logic [8:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        go(1'b0, a, 32'h0);
    endtask
    // Clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Compare each returned read with the oldest note
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (rc !== seen) begin
            seen <= rc;
            eq = exp_q.pop_front();
            `CHK("read data", eq, rq)
        end
    end
    // Main sequence
    initial begin
        reset_n = 1'b0;
        oc = 16'($random(seed));
        ol = 16'($random(seed));
        {od, fb} = $random(seed);
        {fl, pl} = $random(seed);
        {ib, il} = $random(seed);
        oe = 16'($random(seed));
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        rd(sdoc_pkg::REG_COUNTS, 32'h0);
        wr(9'h1fc, 32'hffff_ffff);
        rd(9'h1fc, 32'h0);
        wr(sdoc_pkg::REG_OUT_DATA, {16'h0, od});
        rd(ST, {16'h0, od}); // Normal data
        wr(C, {16'h0, fb});
        wr(C + 9'h004, {16'h0, fl});
        wr(C + 9'h010, {16'h0, pl});
        wr(sdoc_pkg::REG_HOLD_BASE, 32'h1);
        wr(CN, 32'h1);
        ex = (fb & fl) | (~fb & od);
        rd(ST, {16'h0, ex}); // Fault levels
        repeat (9900) @(posedge clk);
        rd(ST, {16'h0, ex}); // Still held
        repeat (200) @(posedge clk);
        ex[0] = pl[0];
        rd(ST, {16'h0, ex}); // Final level
        wr(CN, 32'h0);
        wr(C + 9'h008, {16'h0, ib});
        wr(C + 9'h00c, {16'h0, il});
        wr(CN, 32'h2);
        ex = (ib & il) | (~ib & od);
        rd(ST, {16'h0, ex}); // Idle levels
        wr(CN, 32'h3);
        rd(ST, {16'h0, ex}); // Stays idle
        wr(C + 9'h014, 32'hffff);
        ex = (fb & fl) | (~fb & ex);
        rd(ST, {16'h0, ex}); // Moves to fault
        wr(CN, 32'h0);
        wr(C + 9'h018, {16'h0, oe});
        repeat (4) @(posedge clk);
        rd(sdoc_pkg::REG_FLAGS, {oe & ol, oc}); // Pin flags
        wr(sdoc_pkg::REG_TIMED_SEL, 32'h4);
        wr(SUB, 32'h0102_0101); // Late one, new sequence
        repeat (40) @(posedge clk);
        rd(SL, 32'h3); // Late one applied at once
        rd(ST, {16'h0004, od | 16'h0004}); // Late still drives
        wr(sdoc_pkg::REG_SCHED_DELTA, 32'(cyc / 100 + 40));
        wr(SUB, 32'h0002_0302); // Skips one sequence
        rd(SL + 9'h004, 32'h1); // Waits for its time
        repeat (6000) @(posedge clk);
        rd(SL + 9'h004, 32'h3); // Applied
        rd(sdoc_pkg::REG_COUNTS, 32'h0001_0001); // Counters
        rd(ST, {16'h0, od & 16'hfffb}); // Scheduled level
        wr(SUB, 32'h00ff_0403);
        wr(SUB, 32'h0002_0404);
        repeat (40) @(posedge clk);
        rd(SL + 9'h008, 32'h4); // No target
        rd(SL + 9'h00c, 32'h0); // Same sequence ignored
        repeat (4) @(posedge clk);
        conclude();
    end
endmodule

`default_nettype wire
